//--- inc/pulse_train_pkg.sv
package pulse_train_pkg;
   localparam int TICK_NS = 25;
   localparam int CLK_NS = 100;
   localparam logic [31:0] TICKS_PER_CLK = 32'(CLK_NS / TICK_NS);
   localparam int PERIOD_MIN_NS = 100;
   localparam logic [31:0] PERIOD_MIN = 32'(PERIOD_MIN_NS / TICK_NS);
   localparam logic [63:0] PERIOD_MAX_S = 64'd100;
   localparam logic [31:0] PERIOD_MAX = 32'(PERIOD_MAX_S * 64'd1000000000 / 64'(TICK_NS));
   localparam logic [63:0] WIDTH_MAX_CS = 64'd9999;
   localparam logic [31:0] WIDTH_MAX = 32'(WIDTH_MAX_CS * 64'd10000000 / 64'(TICK_NS));
   localparam logic [31:0] MAX_POINTS = 32'd50000;
   localparam int PULSES_MAX = 10;
   localparam logic signed [15:0] LEVEL_MAX = 16'sd5000;
   localparam logic [10:0] AMP_FULL = 11'h400;
   localparam int AMP_SHIFT = 10;
   localparam logic [31:0] PERIOD_RST = 32'd4000;
   localparam logic [31:0] WIDTH_RST = 32'd2000;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam logic [7:0] REG_SETUP_PERIOD = 8'h0C;
   localparam logic [7:0] REG_FREQ_PERIOD = 8'h10;
   localparam logic [7:0] REG_BASELINE = 8'h14;
   localparam logic [7:0] REG_AMPLITUDE = 8'h18;
   localparam logic [7:0] REG_POINTS = 8'h1C;
   localparam logic [7:0] REG_DWELL = 8'h20;
   localparam logic [7:0] REG_PULSE_BASE = 8'h40;
   localparam int CTRL_PAUSE_EN = 0;
   localparam int CTRL_MAN_PAUSE = 1;
   localparam int CTRL_FINISH = 2;
   localparam int STATUS_BUILDING = 2;
   typedef enum logic [1:0] {
      P_NONE = 2'b00,
      P_MAN = 2'b01,
      P_EXT = 2'b10
   } pause_e;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DWELL = 3'b001,
      S_NPTS = 3'b010,
      S_LOAD = 3'b011,
      S_WID = 3'b100,
      S_DEL = 3'b101,
      S_FREQ = 3'b110
   } build_e;
endpackage : pulse_train_pkg

//--- logic/pulse_train_gen.sv
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module pulse_train_gen
   import pulse_train_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ext_pause_n,
   output logic signed [15:0] sample,
   output logic sync_out
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic pause_en;
      logic man;
      logic [1:0] ext_sy;
      logic [3:0] count;
      logic [31:0] period;
      logic signed [15:0] base;
      logic [10:0] amp;
      logic [PULSES_MAX-1:0][15:0] level;
      logic [PULSES_MAX-1:0][31:0] width;
      logic [PULSES_MAX-1:0][31:0] delay;
      logic [PULSES_MAX-1:0][15:0] wpts;
      logic [PULSES_MAX-1:0][16:0] dpts;
      logic [PULSES_MAX-1:0] fresh;
      logic dirty;
      logic [15:0] npts;
      logic [15:0] npts_old;
      logic [31:0] dwell;
      build_e st;
      logic [3:0] idx;
      logic [31:0] num;
      logic [31:0] quo;
      logic [32:0] rem;
      logic [31:0] den;
      logic [5:0] dcnt;
      logic neg;
      logic [15:0] pt;
      logic [31:0] acc;
      logic signed [15:0] smp;
      logic sync;
   } state_s;

   state_s s, n;
   logic req, building, paused;
   pause_e pstate;

   function automatic logic [31:0] clampu(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
      clampu = (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : clampu

   function automatic logic [15:0] clampl(logic [31:0] v);
      logic signed [31:0] x;
      x = signed'(v);
      if (x > 32'(LEVEL_MAX)) clampl = LEVEL_MAX;
      else if (x < -32'(LEVEL_MAX)) clampl = -LEVEL_MAX;
      else clampl = x[15:0];
   endfunction : clampl

   assign req = avs_read | avs_write;
   assign building = (s.st != S_IDLE);
   assign avs_waitrequest = req & ~s.ack;
   assign avs_readdata = s.rdata;
   assign sample = s.smp;
   assign sync_out = s.sync;

   // Manual wins the report when both sources hold
   always_comb begin
      if (!s.pause_en) pstate = P_NONE;
      else if (s.man) pstate = P_MAN;
      else if (!s.ext_sy[1]) pstate = P_EXT;
      else pstate = P_NONE;
   end
   assign paused = (pstate != P_NONE);

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [3:0] pi;
      logic [3:0] ai;
      logic [32:0] r;
      logic [31:0] m;
      logic [16:0] st0;
      logic [16:0] off;
      logic signed [15:0] lvl;
      logic signed [27:0] prod;
      logic trig;
      pi = 4'(avs_address[7:4] - 4'h4);
      ai = {2'b00, avs_address[3:2]};
      r = '0;
      m = '0;
      st0 = '0;
      off = '0;
      lvl = s.base;
      prod = '0;
      trig = 1'b0;
      n = s;
      n.ext_sy = {s.ext_sy[0], ext_pause_n};
      // Bus slave: answer on the second edge, writes held off while building
      n.ack = req & ~s.ack & ~(avs_write & building);
      if (req && !s.ack) begin
         n.rdata = '0;
         case (avs_address)
            REG_CTRL: n.rdata[CTRL_PAUSE_EN] = s.pause_en;
            REG_STATUS: n.rdata = {29'h0, building, pstate};
            REG_COUNT: n.rdata = {28'h0, s.count};
            REG_SETUP_PERIOD, REG_FREQ_PERIOD: n.rdata = s.period;
            REG_BASELINE: n.rdata = 32'(s.base);
            REG_AMPLITUDE: n.rdata = {21'h0, s.amp};
            REG_POINTS: n.rdata = {16'h0, s.npts};
            REG_DWELL: n.rdata = s.dwell;
            default: begin
               if (avs_address >= REG_PULSE_BASE && pi < 4'(PULSES_MAX)) begin
                  case (ai)
                     4'h0: n.rdata = 32'(signed'(s.level[pi]));
                     4'h1: n.rdata = s.width[pi];
                     4'h2: n.rdata = s.delay[pi];
                     default: n.rdata = 32'(s.wpts[pi] * s.dwell);
                  endcase
               end
            end
         endcase
      end
      if (avs_write && s.ack) begin
         case (avs_address)
            REG_CTRL: begin
               n.pause_en = avs_writedata[CTRL_PAUSE_EN];
               if (avs_writedata[CTRL_MAN_PAUSE]) n.man = ~s.man;
               trig = avs_writedata[CTRL_FINISH];
            end
            REG_COUNT: begin
               n.count = 4'(clampu(avs_writedata, 32'd1, 32'(PULSES_MAX)));
               n.dirty = 1'b1;
            end
            REG_SETUP_PERIOD: begin
               n.period = clampu(avs_writedata, PERIOD_MIN, PERIOD_MAX);
               n.dirty = 1'b1;
            end
            REG_FREQ_PERIOD: begin
               // Point count fixed, so the floor is one tick per point
               n.period = clampu(avs_writedata, clampu({16'h0, s.npts}, PERIOD_MIN,
                  PERIOD_MAX), PERIOD_MAX);
               n.num = n.period;
               n.den = {16'h0, s.npts};
               n.rem = '0;
               n.dcnt = 6'd32;
               n.st = S_FREQ;
            end
            REG_BASELINE: begin
               n.base = clampl(avs_writedata);
               n.dirty = 1'b1;
            end
            REG_AMPLITUDE: n.amp = 11'(clampu(avs_writedata, 32'd0, {21'h0, AMP_FULL}));
            default: begin
               if (avs_address >= REG_PULSE_BASE && pi < 4'(PULSES_MAX)) begin
                  n.dirty = 1'b1;
                  case (ai)
                     4'h0: n.level[pi] = clampl(avs_writedata);
                     4'h1: begin
                        n.width[pi] = clampu(avs_writedata, 32'd1, WIDTH_MAX);
                        n.fresh[pi] = 1'b1;
                     end
                     4'h2: begin
                        n.delay[pi] = avs_writedata;
                        n.fresh[pi] = 1'b1;
                        trig = (pi == s.count - 4'd1);
                     end
                     default: n.dirty = s.dirty;
                  endcase
               end
            end
         endcase
      end
      if (trig && n.dirty && !building) begin
         n.num = n.period + MAX_POINTS - 32'd1;
         n.den = MAX_POINTS;
         n.rem = '0;
         n.dcnt = 6'd32;
         n.npts_old = s.npts;
         n.st = S_DWELL;
      end
      ////////////////////////////////////////////////////////////////////////////////
      // Shared restoring divider, one quotient bit per clock
      if (building && s.dcnt != 6'd0) begin
         r = {s.rem[31:0], s.num[31]};
         n.num = {s.num[30:0], 1'b0};
         n.quo = {s.quo[30:0], r >= {1'b0, s.den}};
         n.rem = (r >= {1'b0, s.den}) ? r - {1'b0, s.den} : r;
         n.dcnt = s.dcnt - 6'd1;
      end else begin
         case (s.st)
            S_IDLE: ;
            S_DWELL: begin
               n.dwell = (s.quo == 32'd0) ? 32'd1 : s.quo;
               n.num = s.period;
               n.den = n.dwell;
               n.rem = '0;
               n.dcnt = 6'd32;
               n.st = S_NPTS;
            end
            S_NPTS: begin
               n.npts = 16'(clampu(s.quo, 32'd1, MAX_POINTS));
               n.idx = 4'd0;
               n.st = S_LOAD;
            end
            S_LOAD: begin
               // Untouched pulses keep their fraction of the period
               m = 32'(s.wpts[s.idx] * s.npts);
               n.num = s.fresh[s.idx] ? s.width[s.idx] : m;
               n.den = s.fresh[s.idx] ? s.dwell : {16'h0, s.npts_old};
               n.rem = '0;
               n.dcnt = 6'd32;
               n.st = S_WID;
            end
            S_WID: begin
               n.wpts[s.idx] = s.quo[15:0];
               n.neg = s.fresh[s.idx] ? s.delay[s.idx][31] : s.dpts[s.idx][16];
               m = 32'((s.dpts[s.idx][16] ? 17'(-s.dpts[s.idx]) : s.dpts[s.idx]) * s.npts);
               n.num = s.fresh[s.idx] ? (s.delay[s.idx][31] ? -s.delay[s.idx] :
                  s.delay[s.idx]) : m;
               n.den = s.fresh[s.idx] ? s.dwell : {16'h0, s.npts_old};
               n.rem = '0;
               n.dcnt = 6'd32;
               n.st = S_DEL;
            end
            S_DEL: begin
               m = (s.quo >= {16'h0, s.npts}) ? {16'h0, s.npts} - 32'd1 : s.quo;
               n.dpts[s.idx] = s.neg ? 17'(-m) : 17'(m);
               n.fresh[s.idx] = 1'b0;
               n.idx = s.idx + 4'd1;
               n.st = (s.idx == s.count - 4'd1) ? S_IDLE : S_LOAD;
               n.dirty = (s.idx == s.count - 4'd1) ? 1'b0 : s.dirty;
            end
            S_FREQ: begin
               n.dwell = (s.quo == 32'd0) ? 32'd1 : s.quo;
               n.st = S_IDLE;
            end
            default: n.st = S_IDLE;
         endcase
      end
      ////////////////////////////////////////////////////////////////////////////////
      // Playback; one point per clock at most, so short dwells stretch
      for (int i = 0; i < PULSES_MAX; i++) begin
         if (4'(i) < s.count) begin
            st0 = s.dpts[i][16] ? 17'({1'b0, s.npts} + s.dpts[i]) : s.dpts[i];
            off = ({1'b0, s.pt} >= st0) ? {1'b0, s.pt} - st0 : {1'b0, s.pt} + {1'b0, s.npts} - st0;
            if (off < {1'b0, s.wpts[i]}) lvl = signed'(s.level[i]);
         end
      end
      prod = lvl * signed'({1'b0, s.amp});
      if (!building && !paused) begin
         n.smp = prod[AMP_SHIFT+15:AMP_SHIFT];
         n.sync = (s.pt == 16'h0);
         if (s.acc + TICKS_PER_CLK >= s.dwell) begin
            n.acc = (s.dwell <= TICKS_PER_CLK) ? 32'h0 : s.acc + TICKS_PER_CLK - s.dwell;
            n.pt = (s.pt + 16'h1 >= s.npts) ? 16'h0 : s.pt + 16'h1;
         end else begin
            n.acc = s.acc + TICKS_PER_CLK;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s <= '0;
         s.ext_sy <= 2'b11;
         s.count <= 4'h1;
         s.period <= PERIOD_RST;
         s.amp <= AMP_FULL;
         s.width <= {PULSES_MAX{WIDTH_RST}};
         s.fresh <= '1;
         s.dirty <= 1'b1;
         s.npts <= 16'(PERIOD_RST);
         s.dwell <= 32'h1;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_count_range: assert property (@(posedge core_clk) disable iff (!resetn)
      s.count >= 4'd1 && s.count <= 4'(PULSES_MAX)) else $error("count out of range");
   a_period_range: assert property (@(posedge core_clk) disable iff (!resetn)
      s.period >= PERIOD_MIN && s.period <= PERIOD_MAX) else $error("period out of range");
   a_level_range: assert property (@(posedge core_clk) disable iff (!resetn)
      s.base <= LEVEL_MAX && s.base >= -LEVEL_MAX) else $error("baseline out of range");
   a_points_max: assert property (@(posedge core_clk) disable iff (!resetn)
      s.npts <= 16'(MAX_POINTS) && s.npts != 16'h0 && s.dwell != 32'h0)
      else $error("point count or dwell bad");
   a_pause_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      paused && !building |=> $stable(s.pt) && $stable(s.smp)) else $error("moved while paused");
   a_ext_pause: assert property (@(posedge core_clk) disable iff (!resetn)
      s.pause_en && !s.man && !ext_pause_n && !building ##2 !ext_pause_n |=> $stable(s.pt))
      else $error("external pause ignored");
   a_freq_points: assert property (@(posedge core_clk) disable iff (!resetn)
      s.st == S_FREQ |-> $stable(s.npts)) else $error("frequency path changed points");
   a_build_done: assert property (@(posedge core_clk) disable iff (!resetn)
      s.st == S_DWELL && $past(s.st) == S_IDLE |-> ##[1:800] s.st == S_IDLE && !s.dirty)
      else $error("build did not finish");
   a_man_toggle: assert property (@(posedge core_clk) disable iff (!resetn)
      avs_write && s.ack && avs_address == REG_CTRL && avs_writedata[CTRL_MAN_PAUSE]
      |=> s.man != $past(s.man)) else $error("manual pause not toggled");
endmodule : pulse_train_gen

//--- test/ext_pause_src.sv
`timescale 1ns/100ps
module ext_pause_src (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic hold_req,
   output logic ext_pause_n
);
   // Idle high; low only while a hold is asked for
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ext_pause_n <= 1'b1;
      end else begin
         ext_pause_n <= ~hold_req;
      end
   end
endmodule : ext_pause_src

//--- test/testbench.sv
`timescale 1ns/100ps
module testbench;
   import pulse_train_pkg::*;
   logic core_clk, resetn, avs_read, avs_write, hold_req, avs_waitrequest, ext_pause_n;
   logic sync_out, prev;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic signed [15:0] sample, held;
   int err_count, n_compared, hi, odd, i;
   logic [31:0] cin [4] = '{32'h0, 32'hB, 32'hA, 32'h1};
   logic [31:0] cexp [4] = '{32'h1, 32'hA, 32'hA, 32'h1};
   pulse_train_gen i_dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_pause_n(ext_pause_n), .sample(sample), .sync_out(sync_out));
   ext_pause_src i_src (.core_clk(core_clk), .resetn(resetn), .hold_req(hold_req),
      .ext_pause_n(ext_pause_n));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task conclude();
      if (err_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task fail_out();
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      conclude();
   endtask : fail_out
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Waitrequest and read data taken as they stood at the rising edge
   task access(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 2000) fail_out();
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : access
   task wr(input logic [7:0] a, input logic [31:0] d);
      access(1'b1, a, d);
   endtask : wr
   task rdck(input logic [7:0] a, input logic [31:0] exp);
      access(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdck
   // Reads are never held off, so status is polled during a build
   task wait_build();
      int n;
      for (n = 0; n < 200; n++) begin
         access(1'b0, REG_STATUS, 32'h0);
         if (rd[STATUS_BUILDING] === 1'b0) return;
      end
      fail_out();
   endtask : wait_build
   // Returns at the first sample that carries a fresh sync rise
   task find_sync();
      int n;
      n = 0;
      do begin
         prev = sync_out;
         @(negedge core_clk);
         n++;
      end while (!(sync_out === 1'b1 && prev === 1'b0) && n < 5000);
      if (n >= 5000) fail_out();
   endtask : find_sync
   // One period from sync rise to sync rise; sync may span several clocks
   task measure(input logic signed [15:0] lh, input logic signed [15:0] ll, input int plen,
      input int pw);
      int n;
      find_sync();
      n = 0;
      hi = 0;
      odd = 0;
      do begin
         prev = sync_out;
         if (sample === lh) hi++;
         else if (sample !== ll) odd++;
         n++;
         @(negedge core_clk);
      end while (!(sync_out === 1'b1 && prev === 1'b0) && n < 5000);
      check(32'(n), 32'(plen));
      check(32'(hi), 32'(pw));
      check(32'(odd), 32'h0);
   endtask : measure
   // A full pattern period, so a running output could not stay flat
   task freeze();
      logic hs;
      repeat (4) @(negedge core_clk);
      held = sample;
      hs = sync_out;
      odd = 0;
      repeat (200) begin
         @(negedge core_clk);
         if (sample !== held || sync_out !== hs) odd++;
      end
      check(32'(odd), 32'h0);
   endtask : freeze
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      hold_req = 1'b0;
      err_count = 0;
      n_compared = 0;
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      rdck(REG_COUNT, 32'h1);
      rdck(REG_FREQ_PERIOD, 32'hFA0);
      rdck(REG_STATUS, 32'h0);
      wr(8'h3C, 32'h5);
      rdck(8'h3C, 32'h0);
      wr(REG_POINTS, 32'h7);
      rdck(REG_POINTS, 32'hFA0);
      for (i = 0; i < 4; i++) begin
         wr(REG_COUNT, cin[i]);
         rdck(REG_COUNT, cexp[i]);
      end
      // Out-of-range levels clamp to full scale and read back sign-extended
      for (i = 0; i < 2; i++) begin
         wr(i ? REG_PULSE_BASE : REG_BASELINE, 32'd6000);
         access(1'b0, i ? REG_PULSE_BASE : REG_BASELINE, 32'h0);
         check(rd, 32'h1388);
         wr(i ? REG_PULSE_BASE : REG_BASELINE, 32'hFFFFE890);
         access(1'b0, i ? REG_PULSE_BASE : REG_BASELINE, 32'h0);
         check(rd, 32'hFFFFEC78);
      end
      wr(REG_SETUP_PERIOD, 32'h190);
      wr(REG_BASELINE, 32'hFFFFFC18);
      wr(REG_PULSE_BASE, 32'h3E8);
      wr(REG_PULSE_BASE + 8'h04, 32'h28);
      wr(REG_PULSE_BASE + 8'h08, 32'h0);
      wait_build();
      rdck(REG_POINTS, 32'h190);
      rdck(REG_DWELL, 32'h1);
      rdck(REG_PULSE_BASE + 8'h0C, 32'h28);
      measure(16'sd1000, -16'sd1000, 400, 40);
      wr(REG_AMPLITUDE, 32'h200);
      measure(16'sd500, -16'sd500, 400, 40);
      wr(REG_AMPLITUDE, 32'h400);
      wr(REG_FREQ_PERIOD, 32'hC80);
      wait_build();
      rdck(REG_POINTS, 32'h190);
      rdck(REG_DWELL, 32'h8);
      measure(16'sd1000, -16'sd1000, 800, 80);
      wr(REG_FREQ_PERIOD, 32'h64);
      rdck(REG_FREQ_PERIOD, 32'h190);
      wr(REG_SETUP_PERIOD, 32'hC8);
      wr(REG_CTRL, 32'h4);
      wait_build();
      rdck(REG_POINTS, 32'hC8);
      rdck(REG_PULSE_BASE + 8'h0C, 32'h14);
      rdck(REG_PULSE_BASE + 8'h04, 32'h28);
      measure(16'sd1000, -16'sd1000, 200, 20);
      wr(REG_PULSE_BASE + 8'h04, 32'h64);
      rdck(REG_PULSE_BASE + 8'h0C, 32'h14);
      wr(REG_PULSE_BASE + 8'h08, 32'h0);
      wait_build();
      rdck(REG_PULSE_BASE + 8'h0C, 32'h64);
      // Hold line ignored while pausing is disabled
      hold_req <= 1'b1;
      repeat (8) @(posedge core_clk);
      rdck(REG_STATUS, 32'h0);
      measure(16'sd1000, -16'sd1000, 200, 100);
      hold_req <= 1'b0;
      repeat (8) @(posedge core_clk);
      wr(REG_CTRL, 32'h3);
      rdck(REG_STATUS, 32'h1);
      freeze();
      wr(REG_CTRL, 32'h3);
      rdck(REG_STATUS, 32'h0);
      measure(16'sd1000, -16'sd1000, 200, 100);
      hold_req <= 1'b1;
      repeat (8) @(posedge core_clk);
      rdck(REG_STATUS, 32'h2);
      freeze();
      hold_req <= 1'b0;
      repeat (8) @(posedge core_clk);
      rdck(REG_STATUS, 32'h0);
      measure(16'sd1000, -16'sd1000, 200, 100);
      // Sync sample shows the phase: after sync, before it, clamped
      wr(REG_PULSE_BASE + 8'h08, 32'h32);
      wait_build();
      find_sync();
      check(32'(sample), 32'hFFFFFC18);
      wr(REG_PULSE_BASE + 8'h08, 32'hFFFFFFCE);
      wait_build();
      find_sync();
      check(32'(sample), 32'h3E8);
      wr(REG_PULSE_BASE + 8'h08, 32'h1000);
      wait_build();
      find_sync();
      check(32'(sample), 32'h3E8);
      conclude();
   end
endmodule : testbench
